// [verilog/sdcr_pkg.sv]
package sdcr_pkg;
    // Register indices; byte address is index times four
    localparam logic [2:0] SDCR_IDX_INT_CHANNEL_NUMERATOR  = 3'h0;
    localparam logic [2:0] SDCR_IDX_PRE_PHASE = 3'h1;
    localparam logic [2:0] SDCR_IDX_REF_PUMP  = 3'h2;
    localparam logic [2:0] SDCR_IDX_OUT_DIV   = 3'h4;
    localparam logic [2:0] SDCR_IDX_STATUS    = 3'h6;
    localparam int SDCR_ADDR_LSB = 2;
    localparam int SDCR_ADDR_MSB = 4;

    localparam int SDCR_SEL_LSB  = 0;
    localparam int SDCR_SEL_W    = 3;
    // Register zero
    localparam int SDCR_WHOLE_LSB = 15;
    localparam int SDCR_WHOLE_W   = 16;
    localparam int SDCR_NUM_LSB   = 3;
    localparam int SDCR_NUM_W     = 12;
    // Register one
    localparam int SDCR_PRE_BIT   = 27;
    localparam int SDCR_PHASE_LSB = 15;
    localparam int SDCR_PHASE_W   = 12;
    localparam int SDCR_DEN_LSB   = 3;
    localparam int SDCR_DEN_W     = 12;
    // Register two
    localparam int SDCR_NOISE_LSB = 29;
    localparam int SDCR_NOISE_W   = 2;
    localparam int SDCR_MUX_LSB   = 26;
    localparam int SDCR_MUX_W     = 3;
    localparam int SDCR_DBL_BIT   = 25;
    localparam int SDCR_HALF_BIT  = 24;
    localparam int SDCR_RCNT_LSB  = 14;
    localparam int SDCR_RCNT_W    = 10;
    localparam int SDCR_DBUF_BIT  = 13;
    localparam int SDCR_PUMP_LSB  = 9;
    localparam int SDCR_PUMP_W    = 3;
    // Register four output divider select
    localparam int SDCR_ODIV_LSB  = 20;
    localparam int SDCR_ODIV_W    = 3;

    localparam logic [1:0] SDCR_NOISE_LOW_NOISE = 2'h0;
    localparam logic [1:0] SDCR_NOISE_LOW_SPUR  = 2'h3;

    localparam logic [9:0]  SDCR_RCNT_RESET  = 10'h001;
    localparam logic [11:0] SDCR_DEN_RESET   = 12'h002;
    localparam logic [11:0] SDCR_PHASE_RESET = 12'h001;
    localparam logic [31:0] SDCR_ZERO_WORD   = 32'h00000000;

    typedef enum logic [1:0] {
        SDCR_IDLE,
        SDCR_ACCESS
    } sdcr_state_t;
endpackage

// [verilog/sdcr_commit_if.sv]
`timescale 1ns/1ps
interface sdcr_commit_if;
    logic        load;
    logic [2:0]  sel;
    logic [31:0] word;
    logic        commit;

    modport bus  (output load, output sel, output word, input commit);
    modport bank (input load, input sel, input word, output commit);
endinterface

// [verilog/sdcr_apb_slave.sv]
`timescale 1ns/1ps
module sdcr_apb_slave (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic        pready,
    output      logic        pslverr,
    output      logic [31:0] prdata,
    // Status word to read
    input  wire logic [31:0] statusWord,
    // Toward register bank
    sdcr_commit_if.bus       cif
);
    sdcr_pkg::sdcr_state_t state;
    logic                  setup;

    assign setup = psel && !penable;

    // One wait-free answer: ready in every access phase
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= sdcr_pkg::SDCR_IDLE;
        end else if (setup) begin
            state <= sdcr_pkg::SDCR_ACCESS;
        end else begin
            state <= sdcr_pkg::SDCR_IDLE;
        end
    end

    assign pready = psel && penable && state == sdcr_pkg::SDCR_ACCESS;

    function automatic logic addrHit(input logic [31:0] a);
        addrHit = (a[1:0] == 2'h0) && (a[31:5] == 27'h0);
    endfunction

    logic [2:0] idx;
    logic       wrOk;
    assign idx  = paddr[sdcr_pkg::SDCR_ADDR_MSB:sdcr_pkg::SDCR_ADDR_LSB];
    assign wrOk = addrHit(paddr) && (idx == sdcr_pkg::SDCR_IDX_INT_CHANNEL_NUMERATOR
                  || idx == sdcr_pkg::SDCR_IDX_PRE_PHASE
                  || idx == sdcr_pkg::SDCR_IDX_REF_PUMP
                  || idx == sdcr_pkg::SDCR_IDX_OUT_DIV);

    // Writes to the status word or unmapped space are errored
    assign pslverr = pready && (pwrite ? !wrOk
                     : !(addrHit(paddr) && idx == sdcr_pkg::SDCR_IDX_STATUS));

    assign cif.load = pready && pwrite && wrOk;
    assign cif.sel  = idx;
    assign cif.word = pwdata;

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= sdcr_pkg::SDCR_ZERO_WORD;
        end else if (setup && !pwrite && addrHit(paddr)
                     && idx == sdcr_pkg::SDCR_IDX_STATUS) begin
            prdata <= statusWord;
        end else if (setup) begin
            prdata <= sdcr_pkg::SDCR_ZERO_WORD;
        end
    end
endmodule

// [verilog/synth_divider_config_regs.sv]
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// What this block does
// - Address bits 4..2 select register zero, one, two or four
// - Register zero bits 30..15 give the integer feedback divisor
// - Register zero bits 14..3 give the modulator numerator
// - Register one bit 27 picks prescaler 4/5 or 8/9
// - Register one bits 26..15 hold the phase word, below denominator
// - Phase word sets output phase in steps of one cycle over denominator
// - Register one bits 14..3 give the fractional modulus
// - Register two bits 30..29 pick low-noise or low-spur operation
// - Dither on for low-spur, off for low-noise
// - Register two bits 28..26 steer the test output multiplexer
// - Register two bit 25 doubles the reference before the counter
// - Doubler off: falling edges act; on: both edges act
// - Register two bit 24 inserts a toggle halver after the counter
// - Register two bits 23..14 give the reference divide ratio 1..1023
// - Register two bit 13 enables double buffering of divider select
// - Register two bits 11..9 give the charge pump current code
// - Buffered fields of registers one and two apply on register zero write
// - Divider select waits for register zero only when bit 13 is set
module synth_divider_config_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic        pready,
    output      logic        pslverr,
    output      logic [31:0] prdata,
    // Reference path
    input  wire logic        referenceInputPin,
    output      logic        phaseDetectorRef,
    // Active settings
    output      logic [15:0] wholePartDivisor,
    output      logic [11:0] channelNumerator,
    output      logic [11:0] channelDenominator,
    output      logic [11:0] phaseWord,
    output      logic        prescalerRatioBit,
    output      logic [1:0]  noiseSpurMode,
    output      logic        ditherEnable,
    output      logic [2:0]  testOutputSelect,
    output      logic [2:0]  pumpCurrentCode,
    output      logic [2:0]  outputDividerSelect,
    output      logic        newSettings
);
    sdcr_commit_if cif ();

    logic [31:0] statusWord;

    sdcr_apb_slave busSlave (
        .clock      (clock),
        .rst        (rst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .prdata     (prdata),
        .statusWord (statusWord),
        .cif        (cif.bus)
    );

    // Staging copies; registers one and two wait for register zero
    logic [31:0] stagePrePhase;
    logic [31:0] stageRefPump;
    logic [2:0]  stageOutDiv;
    logic        doubleBuffer;
    logic        loadZero;
    logic        loadOne;
    logic        loadTwo;
    logic        loadFour;

    assign loadZero = cif.load && cif.sel == sdcr_pkg::SDCR_IDX_INT_CHANNEL_NUMERATOR;
    assign loadOne  = cif.load && cif.sel == sdcr_pkg::SDCR_IDX_PRE_PHASE;
    assign loadTwo  = cif.load && cif.sel == sdcr_pkg::SDCR_IDX_REF_PUMP;
    assign loadFour = cif.load && cif.sel == sdcr_pkg::SDCR_IDX_OUT_DIV;
    assign cif.commit = loadZero;

    always_ff @(posedge clock) begin
        if (rst) begin
            stagePrePhase <= sdcr_pkg::SDCR_ZERO_WORD;
            stageRefPump  <= sdcr_pkg::SDCR_ZERO_WORD;
            stageOutDiv   <= 3'h0;
        end else begin
            if (loadOne) begin
                stagePrePhase <= cif.word;
            end
            if (loadTwo) begin
                stageRefPump <= cif.word;
            end
            if (loadFour) begin
                stageOutDiv <= cif.word[sdcr_pkg::SDCR_ODIV_LSB +: sdcr_pkg::SDCR_ODIV_W];
            end
        end
    end

    // Double buffer flag itself is unbuffered so it governs the next load
    always_ff @(posedge clock) begin
        if (rst) begin
            doubleBuffer <= 1'b0;
        end else if (loadTwo) begin
            doubleBuffer <= cif.word[sdcr_pkg::SDCR_DBUF_BIT];
        end
    end

    // Register zero fields act at once
    always_ff @(posedge clock) begin
        if (rst) begin
            wholePartDivisor <= 16'h0000;
            channelNumerator <= 12'h000;
        end else if (loadZero) begin
            wholePartDivisor <= cif.word[sdcr_pkg::SDCR_WHOLE_LSB +: sdcr_pkg::SDCR_WHOLE_W];
            channelNumerator <= cif.word[sdcr_pkg::SDCR_NUM_LSB +: sdcr_pkg::SDCR_NUM_W];
        end
    end

    // Buffered fields; a write of one or two in the same beat cannot occur
    logic [9:0] refCount;
    logic       refDouble;
    logic       refHalve;

    always_ff @(posedge clock) begin
        if (rst) begin
            prescalerRatioBit  <= 1'b0;
            phaseWord          <= sdcr_pkg::SDCR_PHASE_RESET;
            channelDenominator <= sdcr_pkg::SDCR_DEN_RESET;
            noiseSpurMode      <= sdcr_pkg::SDCR_NOISE_LOW_NOISE;
            testOutputSelect   <= 3'h0;
            refDouble          <= 1'b0;
            refHalve           <= 1'b0;
            refCount           <= sdcr_pkg::SDCR_RCNT_RESET;
            pumpCurrentCode    <= 3'h0;
        end else if (loadZero) begin
            prescalerRatioBit  <= stagePrePhase[sdcr_pkg::SDCR_PRE_BIT];
            phaseWord          <= stagePrePhase[sdcr_pkg::SDCR_PHASE_LSB +: sdcr_pkg::SDCR_PHASE_W];
            channelDenominator <= stagePrePhase[sdcr_pkg::SDCR_DEN_LSB +: sdcr_pkg::SDCR_DEN_W];
            noiseSpurMode      <= stageRefPump[sdcr_pkg::SDCR_NOISE_LSB +: sdcr_pkg::SDCR_NOISE_W];
            testOutputSelect   <= stageRefPump[sdcr_pkg::SDCR_MUX_LSB +: sdcr_pkg::SDCR_MUX_W];
            refDouble          <= stageRefPump[sdcr_pkg::SDCR_DBL_BIT];
            refHalve           <= stageRefPump[sdcr_pkg::SDCR_HALF_BIT];
            refCount           <= stageRefPump[sdcr_pkg::SDCR_RCNT_LSB +: sdcr_pkg::SDCR_RCNT_W];
            pumpCurrentCode    <= stageRefPump[sdcr_pkg::SDCR_PUMP_LSB +: sdcr_pkg::SDCR_PUMP_W];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            outputDividerSelect <= 3'h0;
        end else if (loadFour && !doubleBuffer) begin
            outputDividerSelect <= cif.word[sdcr_pkg::SDCR_ODIV_LSB +: sdcr_pkg::SDCR_ODIV_W];
        end else if (loadZero && doubleBuffer) begin
            outputDividerSelect <= stageOutDiv;
        end
    end

    // Unknown mode codes fall back to no dither
    always_ff @(posedge clock) begin
        if (rst) begin
            ditherEnable <= 1'b0;
        end else begin
            ditherEnable <= noiseSpurMode == sdcr_pkg::SDCR_NOISE_LOW_SPUR;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            newSettings <= 1'b0;
        end else begin
            newSettings <= loadZero;
        end
    end

    // Reference pin is asynchronous: two flops before use
    logic refMeta;
    logic refSync;
    logic refLast;

    always_ff @(posedge clock) begin
        if (rst) begin
            refMeta <= 1'b0;
            refSync <= 1'b0;
            refLast <= 1'b0;
        end else begin
            refMeta <= referenceInputPin;
            refSync <= refMeta;
            refLast <= refSync;
        end
    end

    // Digital stand-in; reference must be well below clock/4
    logic refEdge;
    assign refEdge = refDouble ? (refSync != refLast)
                               : (refLast && !refSync);

    logic [9:0] refCounter;
    logic       counterTick;
    assign counterTick = refEdge && (refCounter <= 10'h001);

    always_ff @(posedge clock) begin
        if (rst) begin
            refCounter <= sdcr_pkg::SDCR_RCNT_RESET;
        end else if (counterTick) begin
            refCounter <= refCount;
        end else if (refEdge) begin
            refCounter <= refCounter - 10'h001;
        end
    end

    logic halfToggle;
    always_ff @(posedge clock) begin
        if (rst) begin
            halfToggle <= 1'b0;
        end else if (counterTick) begin
            halfToggle <= !halfToggle;
        end
    end

    // Without halving, a one-cycle pulse per counter wrap
    always_ff @(posedge clock) begin
        if (rst) begin
            phaseDetectorRef <= 1'b0;
        end else if (refHalve) begin
            phaseDetectorRef <= halfToggle;
        end else begin
            phaseDetectorRef <= counterTick;
        end
    end

    // Read-back of live state; configuration words stay write-only
    assign statusWord = {20'h00000, outputDividerSelect, ditherEnable, 2'h0,
                         noiseSpurMode, doubleBuffer, refHalve, refDouble,
                         prescalerRatioBit};
endmodule

// [dv/sdcr_ref_source.sv]
`timescale 1ns/1ps
// Free-running oscillator, phase unrelated to the bench clock
module sdcr_ref_source #(
    parameter real HALF_NS = 64.3
) (
    // Reference output
    output logic refOut
);
    initial begin
        refOut = 1'b0;
        forever #(HALF_NS) refOut = ~refOut;
    end
endmodule

// [dv/sdcr_assertions.sv]
`timescale 1ns/1ps
module sdcr_assertions (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Settings
    input wire logic [15:0] wholePartDivisor,
    input wire logic [11:0] channelNumerator,
    input wire logic [11:0] channelDenominator,
    input wire logic [11:0] phaseWord,
    input wire logic        prescalerRatioBit,
    input wire logic [1:0]  noiseSpurMode,
    input wire logic        ditherEnable,
    input wire logic [2:0]  testOutputSelect,
    input wire logic [2:0]  pumpCurrentCode,
    input wire logic        newSettings
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire zeroWr;
    assign zeroWr = psel && penable && pwrite && paddr == 32'h00000000;

    chk_ready_access: assert property (pready == (psel && penable))
        else $error("pready outside access phase");
    chk_commit_pulse: assert property (zeroWr |=> newSettings)
        else $error("no commit after word zero");
    chk_commit_cause: assert property (newSettings |-> $past(zeroWr))
        else $error("commit without word zero");
    chk_word0_load: assert property (zeroWr |=> wholePartDivisor == $past(pwdata[30:15])
        && channelNumerator == $past(pwdata[14:3])) else $error("word zero fields wrong");
    chk_staged_hold: assert property (!newSettings |-> $stable({channelDenominator,
        phaseWord, prescalerRatioBit, noiseSpurMode, testOutputSelect, pumpCurrentCode,
        wholePartDivisor})) else $error("setting moved without commit");
    chk_dither_mode: assert property (ditherEnable ==
        ($past(noiseSpurMode) == sdcr_pkg::SDCR_NOISE_LOW_SPUR)) else $error("dither wrong");
    chk_unmapped_err: assert property (psel && penable && paddr == 32'h0000000c |-> pslverr)
        else $error("unmapped access accepted");
    chk_mapped_ok: assert property (psel && penable && pwrite && paddr[31:4] == 28'h0
        && paddr[1:0] == 2'h0 && paddr[3:2] != 2'h3 |-> !pslverr) else $error("write refused");
    chk_write_only: assert property (psel && penable && !pwrite && paddr[31:4] == 28'h0
        |-> pslverr && prdata == 32'h00000000) else $error("config word readable");
    cover property (zeroWr);
    cover property (ditherEnable);
    cover property (pready && pslverr);
endmodule

// [dv/synth_divider_config_regs_bench.sv]
`timescale 1ns/1ps
module synth_divider_config_regs_bench;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, refPin, pdRef;
    logic        preBit, dither, newSet;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] whole;
    logic [11:0] num, den, phase;
    logic [2:0]  muxSel, pump, odiv;
    logic [1:0]  noise;
    int          n_mismatch, checks_done, pulses;
    logic        cfg [3][2] = '{'{1'b0, 1'b0}, '{1'b1, 1'b0}, '{1'b0, 1'b1}};
    int          expP [3] = '{16, 32, 8};

    sdcr_ref_source refModel (.refOut(refPin));
    synth_divider_config_regs uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .referenceInputPin(refPin), .phaseDetectorRef(pdRef),
        .wholePartDivisor(whole), .channelNumerator(num), .channelDenominator(den),
        .phaseWord(phase), .prescalerRatioBit(preBit), .noiseSpurMode(noise),
        .ditherEnable(dither), .testOutputSelect(muxSel), .pumpCurrentCode(pump),
        .outputDividerSelect(odiv), .newSettings(newSet));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ends at a falling edge so committed outputs are settled for checking
    task automatic xfer(input logic w, input logic [31:0] a, d, input logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pready}, 32'h1);
        chk({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
    endtask

    function automatic logic [31:0] w2(logic [1:0] nm, logic dbl, logic half, logic db);
        return {1'b0, nm, 3'h5, dbl, half, 10'h003, db, 1'b0, 3'h6, 6'h00, 3'h2};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        #100us;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({whole, den, phase[3:0]}, {16'h0, 12'h002, 4'h1});
        xfer(1'b1, 32'h4, {4'h0, 1'b1, 12'h005, 12'h064, 3'h1}, 1'b0);
        xfer(1'b1, 32'h8, w2(2'h3, 1'b0, 1'b0, 1'b1), 1'b0);
        xfer(1'b1, 32'h10, 32'h00500004, 1'b0);
        chk({den, 1'b0, odiv}, {12'h002, 4'h0});
        xfer(1'b1, 32'h0, {1'b0, 16'd75, 12'd7, 3'h0}, 1'b0);
        chk({whole, num}, {16'd75, 12'd7});
        chk({den, phase, 3'h0, preBit}, {12'h064, 12'h005, 4'h1});
        chk({noise, muxSel, pump, 1'b0, odiv}, {2'h3, 3'h5, 3'h6, 4'h5});
        @(negedge clock);
        chk({31'h0, dither}, 32'h1);
        xfer(1'b1, 32'hc, 32'hffffffff, 1'b1);
        xfer(1'b0, 32'h0, 32'h0, 1'b1);
        chk(rd, 32'h0);
        xfer(1'b0, 32'h18, 32'h0, 1'b0);
        chk({29'h0, rd[5:4], rd[0]}, 32'h7);
        // Back to 4/5 with the idle phase word for the reference runs
        xfer(1'b1, 32'h4, {4'h0, 1'b0, 12'h001, 12'h064, 3'h1}, 1'b0);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, 32'h8, w2(2'h0, cfg[i][0], cfg[i][1], 1'b0), 1'b0);
            xfer(1'b1, 32'h0, {1'b0, 16'd75, 12'd7, 3'h0}, 1'b0);
            chk({preBit, phase}, {1'b0, 12'h001});
            @(negedge clock);
            chk({31'h0, dither}, 32'h0);
            pulses = 0;
            repeat (768) begin
                rd[0] = pdRef;
                @(negedge clock);
                if (pdRef && !rd[0])
                    pulses++;
            end
            chk({31'h0, pulses >= expP[i] - 1 && pulses <= expP[i] + 1}, 32'h1);
        end
        xfer(1'b1, 32'h10, 32'h00300004, 1'b0);
        chk({29'h0, odiv}, 32'h3);
        report_and_stop();
    end
endmodule

bind synth_divider_config_regs sdcr_assertions chkInst (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .wholePartDivisor(wholePartDivisor),
    .channelNumerator(channelNumerator), .channelDenominator(channelDenominator),
    .phaseWord(phaseWord), .prescalerRatioBit(prescalerRatioBit),
    .noiseSpurMode(noiseSpurMode), .ditherEnable(ditherEnable),
    .testOutputSelect(testOutputSelect), .pumpCurrentCode(pumpCurrentCode),
    .newSettings(newSettings));
